// ---- sib_regs.svh ----
// register offsets, field positions, reset values and timing constants of the i2c transmit channel
`ifndef SIB_REGS_SVH
`define SIB_REGS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SIB_OFF_MODE 8'h00
`define SIB_OFF_COMM 8'h04
`define SIB_OFF_DATA 8'h08
`define SIB_OFF_LEVEL 8'h0c
`define SIB_OFF_OUTEN 8'h10
`define SIB_OFF_START 8'h14
`define SIB_OFF_STATUS 8'h18
`define SIB_OFF_CLEAR 8'h1c
`define SIB_OFF_PRESCALE 8'h20
`define SIB_OFF_STOP 8'h24
// ----------------------------------------
// field positions
// ----------------------------------------
`define SIB_LVL_CLK_BIT 8
`define SIB_LVL_DAT_BIT 0
`define SIB_ST_BUSY_BIT 0
`define SIB_ST_ACKERR_BIT 1
`define SIB_ST_ADDR_BIT 2
`define SIB_DIV_LSB 9
// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define SIB_MODE_RST 16'h0020
`define SIB_COMM_RST 16'h0087
`define SIB_DATA_RST 16'h0000
`define SIB_PRE_RST 8'h00
`define SIB_MD_IIC 3'h4
`define SIB_ACK_BIT 4'h8
`define SIB_DIV_MIN 7'h01
`define SIB_RESP_OKAY 2'h0
`define SIB_RESP_SLVERR 2'h2
`endif

// ---- sib_pkg.sv ----
// types shared by the i2c transmit channel
package sib_pkg;
  // engine states
  typedef enum logic [2:0] {
    SIB_IDLE = 3'b000,
    SIB_LOW = 3'b001,
    SIB_HIGH = 3'b010,
    SIB_SP_LOW = 3'b011,
    SIB_SP_HIGH = 3'b100,
    SIB_SP_DONE = 3'b101
  } sib_state_t;
  // channel mode register layout
  typedef struct packed {
    logic cks;
    logic ccs;
    logic [4:0] rsv_hi;
    logic sts;
    logic rsv_7;
    logic sis;
    logic fixed_5;
    logic [1:0] rsv_lo;
    logic [2:0] md;
  } sib_mode_t;
  // channel operation setting register layout
  typedef struct packed {
    logic txe;
    logic rxe;
    logic dap;
    logic ckp;
    logic rsv_11;
    logic eoc;
    logic [1:0] ptc;
    logic dir;
    logic rsv_6;
    logic [1:0] slc;
    logic rsv_3;
    logic fixed_2;
    logic [1:0] dls;
  } sib_comm_t;
  // open-drain pin pair
  typedef struct packed {
    logic scl;
    logic sda;
  } sib_pins_t;
endpackage

// ---- sib_i2c_tx.sv ----
// i2c master data-transmit channel with axi4-lite register access
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "sib_regs.svh"
module sib_i2c_tx
  import sib_pkg::*;
#(
  parameter int PRE_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe,
  output logic sda_o,
  output logic sda_oe,
  output logic transfer_end_irq
);
  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (PRE_W < 2 || PRE_W > 16) begin : g_bad_pre_w
    $error("PRE_W must lie between 2 and 16");
  end

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // merge the two low byte lanes into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction
  // prescaler tap: all low bits of the counter are ones
  function automatic logic pre_tap(input logic [PRE_W-1:0] cnt, input logic [3:0] ex);
    logic [PRE_W-1:0] mask;
    mask = {PRE_W{1'b1}} >> (PRE_W - int'(ex));
    pre_tap = ((cnt & mask) == mask);
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  sib_mode_t mode_r; // channel mode register
  sib_comm_t comm_r; // operation setting register
  logic [15:0] data_r; // divider and byte to send
  logic [7:0] pre_r; // two prescaler exponents
  logic outen_r; // output enable bit
  logic start_r; // channel start bit
  logic clk_lvl_r; // clock output level
  logic dat_lvl_r; // data output level
  logic ack_err_r; // acknowledge error flag
  logic addr_done_r; // address field already sent
  logic first_r; // next byte is the address field
  sib_state_t state_r; // engine state
  logic [3:0] bit_idx_r; // bit slot 0..8
  logic [7:0] shift_r; // outgoing byte, msb on top
  logic [6:0] hcnt_r; // half-period countdown
  logic [PRE_W-1:0] pre_cnt_r; // free prescaler counter
  logic scl_m_r, scl_s_r, sda_m_r, sda_s_r; // pin synchronisers
  sib_pins_t pin_oe_r; // registered pin enables
  logic irq_r; // transfer end pulse
  logic aw_got_r, w_got_r; // write halves held
  logic [7:0] awaddr_r; // held write address
  logic [31:0] wdata_r; // held write data
  logic [3:0] wstrb_r; // held strobes
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic aw_take, w_take, ar_take, wr_do, wr_ok, mck_tick, half_done;
  logic start_tx, stop_req, busy, ack_end, mode_ok;
  logic [6:0] half_len;
  logic [31:0] rd_val;
  logic rd_ok;

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  assign aw_take = s_axi_awvalid & awready_r;
  assign w_take = s_axi_wvalid & wready_r;
  assign wr_do = aw_got_r & w_got_r & ~bvalid_r;
  // decode of mapped write offsets
  always_comb begin
    case (awaddr_r)
      `SIB_OFF_MODE, `SIB_OFF_COMM, `SIB_OFF_DATA, `SIB_OFF_LEVEL, `SIB_OFF_OUTEN,
      `SIB_OFF_START, `SIB_OFF_STATUS, `SIB_OFF_CLEAR, `SIB_OFF_PRESCALE,
      `SIB_OFF_STOP: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end
  // address and data taken in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `SIB_RESP_OKAY;
    end else begin
      if (aw_take) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      aw_got_r <= (aw_got_r | aw_take) & ~wr_do;
      w_got_r <= (w_got_r | w_take) & ~wr_do;
      awready_r <= ~(aw_got_r | aw_take) | wr_do;
      wready_r <= ~(w_got_r | w_take) | wr_do;
      if (wr_do) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? `SIB_RESP_OKAY : `SIB_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  assign ar_take = s_axi_arvalid & arready_r;
  // read multiplexer, unused bits read zero; reserved bits of mode and comm read back as written
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `SIB_OFF_MODE: rd_val = {16'h0000, mode_r};
      `SIB_OFF_COMM: rd_val = {16'h0000, comm_r};
      `SIB_OFF_DATA: rd_val = {16'h0000, data_r};
      `SIB_OFF_LEVEL: rd_val = {23'h000000, clk_lvl_r, 7'h00, dat_lvl_r};
      `SIB_OFF_OUTEN: rd_val = {31'h00000000, outen_r};
      `SIB_OFF_START: rd_val = {31'h00000000, start_r};
      `SIB_OFF_STATUS: rd_val = {29'h00000000, addr_done_r, ack_err_r, busy};
      `SIB_OFF_PRESCALE: rd_val = {24'h000000, pre_r};
      `SIB_OFF_CLEAR, `SIB_OFF_STOP: rd_val = 32'h0000_0000;
      default: begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end
  // one read at a time, answer the edge after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `SIB_RESP_OKAY;
    end else begin
      arready_r <= ~ar_take & ~(rvalid_r & ~s_axi_rready);
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_val;
        rresp_r <= rd_ok ? `SIB_RESP_OKAY : `SIB_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  // guard: mode code for i2c transfer end
  assign mode_ok = (mode_r.md == `SIB_MD_IIC) && comm_r.txe;
  assign busy = (state_r != SIB_IDLE);
  // byte written while started launches one frame
  assign start_tx = wr_do && (awaddr_r == `SIB_OFF_DATA) && wstrb_r[0] && start_r
                    && outen_r && mode_ok && !busy;
  assign stop_req = wr_do && (awaddr_r == `SIB_OFF_STOP) && wdata_r[0] && start_r && !busy;
  // software-owned registers; mode, data and outen frozen while busy, comm too except txe and rxe; prescaler always writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= `SIB_MODE_RST;
      comm_r <= `SIB_COMM_RST;
      data_r <= `SIB_DATA_RST;
      pre_r <= `SIB_PRE_RST;
      outen_r <= 1'b0;
    end else if (wr_do) begin
      case (awaddr_r)
        `SIB_OFF_MODE: if (!busy) mode_r <= merge16(mode_r, wdata_r, wstrb_r);
        `SIB_OFF_COMM: begin
          if (!busy) begin
            comm_r <= merge16(comm_r, wdata_r, wstrb_r);
          end else if (wstrb_r[1]) begin
            comm_r.txe <= wdata_r[15];
            comm_r.rxe <= wdata_r[14];
          end
        end
        `SIB_OFF_DATA: if (!busy) data_r <= merge16(data_r, wdata_r, wstrb_r);
        `SIB_OFF_PRESCALE: if (wstrb_r[0]) pre_r <= wdata_r[7:0];
        `SIB_OFF_OUTEN: if (!busy && wstrb_r[0]) outen_r <= wdata_r[0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // operation clock and bit timing
  // ----------------------------------------
  // prescaler counter feeding both clock taps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt_r <= '0;
    end else begin
      pre_cnt_r <= pre_cnt_r + 1'b1;
    end
  end
  assign mck_tick = mode_r.cks ? pre_tap(pre_cnt_r, pre_r[7:4]) : pre_tap(pre_cnt_r, pre_r[3:0]);
  // divider clamped so a bit spans at least four ticks
  assign half_len = (data_r[15:`SIB_DIV_LSB] < `SIB_DIV_MIN) ? `SIB_DIV_MIN :
                    data_r[15:`SIB_DIV_LSB];
  assign half_done = mck_tick && (hcnt_r == 7'h00);
  // half-period countdown, reloaded on every phase change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hcnt_r <= 7'h00;
    end else if (start_tx || stop_req || half_done) begin
      hcnt_r <= half_len;
    end else if (mck_tick) begin
      hcnt_r <= hcnt_r - 7'h01;
    end
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
    end else begin
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
    end
  end

  // ----------------------------------------
  // transmit engine
  // ----------------------------------------
  // high phase waits for the line itself, so a stretching slave holds it
  assign ack_end = (state_r == SIB_HIGH) && half_done && scl_s_r && (bit_idx_r == `SIB_ACK_BIT);
  // frame sequencer, level bits and channel start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= SIB_IDLE;
      bit_idx_r <= 4'h0;
      shift_r <= 8'h00;
      clk_lvl_r <= 1'b1;
      dat_lvl_r <= 1'b1;
      start_r <= 1'b0;
    end else begin
      case (state_r)
        SIB_IDLE: begin
          if (start_tx) begin
            shift_r <= wdata_r[7:0];
            bit_idx_r <= 4'h0;
            clk_lvl_r <= 1'b0;
            state_r <= SIB_LOW;
          end else if (stop_req) begin
            clk_lvl_r <= 1'b0;
            state_r <= SIB_SP_LOW;
          end else if (wr_do && wstrb_r[0]) begin
            // software level control, used for the start condition
            if (awaddr_r == `SIB_OFF_LEVEL) begin
              dat_lvl_r <= wdata_r[`SIB_LVL_DAT_BIT];
            end
            if (awaddr_r == `SIB_OFF_START) begin
              start_r <= wdata_r[0];
            end
          end
          if (wr_do && !start_tx && !stop_req && wstrb_r[1] && awaddr_r == `SIB_OFF_LEVEL) begin
            clk_lvl_r <= wdata_r[`SIB_LVL_CLK_BIT];
          end
        end
        SIB_LOW: begin
          // data changes only while the clock is low; ninth slot released
          dat_lvl_r <= (bit_idx_r == `SIB_ACK_BIT) ? 1'b1 : shift_r[7];
          if (half_done) begin
            clk_lvl_r <= 1'b1;
            state_r <= SIB_HIGH;
          end
        end
        SIB_HIGH: begin
          if (half_done && scl_s_r) begin
            clk_lvl_r <= 1'b0;
            if (bit_idx_r == `SIB_ACK_BIT) begin
              state_r <= SIB_IDLE;
            end else begin
              shift_r <= {shift_r[6:0], 1'b0}; // msb first
              bit_idx_r <= bit_idx_r + 4'h1;
              state_r <= SIB_LOW;
            end
          end
        end
        SIB_SP_LOW: begin
          dat_lvl_r <= 1'b0;
          if (half_done) begin
            clk_lvl_r <= 1'b1;
            state_r <= SIB_SP_HIGH;
          end
        end
        SIB_SP_HIGH: begin
          if (half_done && scl_s_r) begin
            dat_lvl_r <= 1'b1;
            state_r <= SIB_SP_DONE;
          end
        end
        SIB_SP_DONE: begin
          if (half_done) begin
            start_r <= 1'b0;
            state_r <= SIB_IDLE;
          end
        end
        default: state_r <= SIB_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // status flags and interrupt
  // ----------------------------------------
  // error flag: a new error wins over a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_err_r <= 1'b0;
    end else if (ack_end && sda_s_r) begin
      ack_err_r <= 1'b1;
    end else if (wr_do && awaddr_r == `SIB_OFF_CLEAR && wstrb_r[0]
                 && wdata_r[`SIB_ST_ACKERR_BIT]) begin
      ack_err_r <= 1'b0;
    end
  end
  // first byte after channel start is the address field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_r <= 1'b1;
      addr_done_r <= 1'b0;
    end else if (!start_r) begin
      first_r <= 1'b1;
      addr_done_r <= 1'b0;
    end else if (ack_end) begin
      first_r <= 1'b0;
      addr_done_r <= addr_done_r | first_r;
    end
  end
  // one-cycle transfer end pulse, raised the cycle after the ninth clock slot ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= ack_end;
    end
  end
  // open-drain drive: enable pulls low whenever a level is zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_oe_r <= '0;
    end else begin
      pin_oe_r.scl <= ~clk_lvl_r;
      pin_oe_r.sda <= ~dat_lvl_r;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = pin_oe_r.scl;
  assign sda_oe = pin_oe_r.sda;
  assign transfer_end_irq = irq_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_launch;
    start_tx;
  endsequence
  sequence s_frame_open;
    (state_r == SIB_LOW) && !clk_lvl_r;
  endsequence
  property p_launch_needs_start;
    s_launch |-> start_r && outen_r && (mode_r.md == `SIB_MD_IIC)
                 && (first_r || addr_done_r);
  endproperty
  a_launch_needs_start: assert property (p_launch_needs_start) else $error("frame w/o start");
  property p_launch_opens;
    s_launch |=> s_frame_open ##1 busy[*2];
  endproperty
  a_launch_opens: assert property (p_launch_opens) else $error("frame did not open");
  property p_irq_follows_ack;
    ack_end |=> transfer_end_irq ##1 !transfer_end_irq;
  endproperty
  a_irq_follows_ack: assert property (p_irq_follows_ack) else $error("irq missing");
  property p_irq_cause;
    transfer_end_irq |-> $past(state_r) == SIB_HIGH && $past(bit_idx_r) == `SIB_ACK_BIT;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("stray irq");
  property p_ack_error;
    ack_end && sda_s_r |=> ack_err_r && transfer_end_irq;
  endproperty
  a_ack_error: assert property (p_ack_error) else $error("ack error lost");
  property p_ninth_released;
    (state_r == SIB_HIGH) && (bit_idx_r == `SIB_ACK_BIT) |-> dat_lvl_r;
  endproperty
  a_ninth_released: assert property (p_ninth_released) else $error("sda held in ack");
  property p_slot_bound;
    busy |-> bit_idx_r <= `SIB_ACK_BIT;
  endproperty
  a_slot_bound: assert property (p_slot_bound) else $error("too many bits");
  property p_msb_first;
    (state_r == SIB_HIGH) && (bit_idx_r < `SIB_ACK_BIT) |-> dat_lvl_r == shift_r[7];
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("wrong data bit");
  property p_stop_release;
    (state_r == SIB_SP_DONE) && half_done |=> !busy && clk_lvl_r && dat_lvl_r && !start_r;
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("bus not released");
  property p_quarter_rate;
    half_done && busy |=> !half_done;
  endproperty
  a_quarter_rate: assert property (p_quarter_rate) else $error("bit rate too fast");
endmodule

// ---- sib_slave_model.sv ----
// behavioural i2c slave that records each byte and answers the ninth slot
`timescale 1ns/1ps
module sib_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic nak,
  output logic sda_oe,
  output logic [7:0] last_byte
);
  int cnt = 0; // bit slot within the frame
  logic [7:0] sh = 8'h00; // incoming bits
  initial sda_oe = 1'b0;
  initial last_byte = 8'h00;
  // ----------------------------------------
  // framing
  // ----------------------------------------
  // start condition restarts the slot count
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      cnt = 0;
    end
  end
  // data taken msb first on the rising clock
  always @(posedge scl) begin
    if (cnt < 8) begin
      sh = {sh[6:0], sda};
    end
    if (cnt == 7) begin
      last_byte = sh;
    end
    cnt = (cnt == 8) ? 0 : cnt + 1;
  end
  // pull low for the ack slot unless told to refuse, release after it
  always @(negedge scl) begin
    sda_oe = (cnt == 8) && !nak;
  end
endmodule

// ---- tb_sib_i2c_tx.sv ----
// self-checking bench for the i2c data-transmit channel
`timescale 1ns/1ps
`include "sib_regs.svh"
module tb_sib_i2c_tx;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, nak = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h3; // byte lanes offered with each write
  logic [31:0] rd;
  logic [1:0] rs;
  logic [7:0] seed = 8'h15; // lfsr start value
  wire awready, wready, bvalid, arready, rvalid, scl_o, sda_o, scl_oe, sda_oe, irq, s_oe;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] last_byte;
  wire scl = ~scl_oe; // pulled-up open-drain clock
  wire sda = ~(sda_oe | s_oe); // pulled-up open-drain data
  int err_total = 0, check_count = 0, cyc = 0, irq_cnt = 0, n;
  always #50 aclk = ~aclk;
  sib_i2c_tx dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .scl_i(scl), .sda_i(sda), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_o(sda_o), .sda_oe(sda_oe), .transfer_end_irq(irq));
  sib_slave_model slv_u (.scl(scl), .sda(sda), .nak(nak), .sda_oe(s_oe),
    .last_byte(last_byte));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one axi write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && k < 200);
    if (bvalid !== 1'b1) err_total++; // write response never came
    r = bresp;
    bready <= 1'b0;
  endtask
  // one axi read
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && k < 200);
    if (rvalid !== 1'b1) err_total++; // read data never came
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic wok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk({30'h0, r}, {30'h0, `SIB_RESP_OKAY});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rdr(a, d, r);
    chk(d & m, e);
  endtask
  // one byte over the link, with a mode write attempted in flight
  task automatic send(input logic [7:0] b, input logic nk);
    int k;
    nak <= nk;
    wok(`SIB_OFF_DATA, 32'h0200 | {24'h0, b});
    wok(`SIB_OFF_MODE, 32'h0000);
    rchk(`SIB_OFF_MODE, 32'hffff, 32'h8024);
    wstrb <= 4'h2; // only the enable byte is offered in flight
    wok(`SIB_OFF_COMM, 32'h80ff);
    wstrb <= 4'h3;
    rchk(`SIB_OFF_COMM, 32'hffff, 32'h8017);
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while (irq !== 1'b1 && k < 2000);
    chk({31'h0, irq}, 32'h1);
    chk({24'h0, last_byte}, {24'h0, b});
    rchk(`SIB_OFF_STATUS, 32'h6, {29'h0, 1'b1, nk, 1'b0});
  endtask
  // ----------------------------------------
  // monitors
  // ----------------------------------------
  always @(posedge aclk) begin
    cyc++;
    if (irq === 1'b1) irq_cnt++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish;
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({30'h0, scl, sda}, 32'h3);
    chk({30'h0, scl_o, sda_o}, 32'h0);
    rchk(`SIB_OFF_MODE, 32'hffff, {16'h0, `SIB_MODE_RST});
    rchk(`SIB_OFF_COMM, 32'hffff, {16'h0, `SIB_COMM_RST});
    rdr(8'h28, rd, rs);
    chk({30'h0, rs}, {30'h0, `SIB_RESP_SLVERR});
    wok(`SIB_OFF_PRESCALE, 32'h0010);
    wok(`SIB_OFF_MODE, 32'h8024);
    wok(`SIB_OFF_COMM, 32'h8017);
    rchk(`SIB_OFF_COMM, 32'hffff, 32'h8017);
    wok(`SIB_OFF_LEVEL, 32'h0100);
    @(posedge aclk);
    chk({30'h0, scl, sda}, 32'h2);
    wok(`SIB_OFF_OUTEN, 32'h1);
    wok(`SIB_OFF_START, 32'h1);
    send(8'ha4, 1'b0);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr_next(seed);
      send(seed, i == 2);
      if (i == 2) begin
        wok(`SIB_OFF_CLEAR, 32'h2);
        rchk(`SIB_OFF_STATUS, 32'h2, 32'h0);
      end
    end
    wok(`SIB_OFF_STOP, 32'h1);
    n = 0;
    do begin
      rdr(`SIB_OFF_STATUS, rd, rs);
      n++;
    end while (rd[0] !== 1'b0 && n < 100);
    chk(rd & 32'h1, 32'h0);
    chk({30'h0, scl, sda}, 32'h3);
    chk(irq_cnt, 5);
    tally_and_finish;
  end
endmodule
